// file: event_counter_pkg.sv
package event_counter_pkg;

	localparam int          NUM_COUNTERS   = 31;
	localparam int          VALUE_W        = 20;
	localparam int          MODE_W         = 4;
	localparam int          INDEX_W        = 5;

	// Count limits
	localparam logic [19:0] VALUE_MAX      = 20'hF_423F;
	localparam logic [19:0] OVERFLOW_MAX   = 20'h0_FFFF;
	localparam logic [19:0] VALUE_ZERO     = 20'h0_0000;

	// Scan cycle timing
	localparam int          CLK_MHZ        = 125;
	localparam int          SCAN_TIME_US   = 10;
	localparam int          SCAN_CYCLES    = SCAN_TIME_US * CLK_MHZ;

	// Wishbone map: adr[8:7] selects region, adr[6:2] the instance
	localparam logic [1:0]  REGION_CONFIG  = 2'h0;
	localparam logic [1:0]  REGION_PRESET  = 2'h1;
	localparam logic [1:0]  REGION_VALUE   = 2'h2;
	localparam logic [1:0]  REGION_STATUS  = 2'h3;
	localparam logic [4:0]  STATUS_COILS   = 5'h00;
	localparam logic [4:0]  STATUS_FAST    = 5'h01;
	localparam int          REGION_LSB     = 7;
	localparam int          INDEX_LSB      = 2;

	// Config register fields
	localparam int          CFG_MODE_LSB   = 0;
	localparam int          CFG_KEEP_BIT   = 4;
	localparam int          CFG_FAST_BIT   = 5;
	localparam logic [3:0]  CFG_MODE_RESET = 4'h0;
	localparam logic [19:0] PRESET_RESET   = 20'h0_0000;

	typedef enum logic [3:0] {
		MODE_COIL,
		MODE_STOP_VOLATILE,
		MODE_OVER_VOLATILE,
		MODE_STOP_KEEP,
		MODE_OVER_KEEP,
		MODE_CMP_VOLATILE,
		MODE_CMP_KEEP,
		MODE_FAST
	} mode_t;

endpackage

// file: ladder_model.sv
`timescale 1ns/1ps
module ladder_model #(
	parameter int SCAN = 4
) (
	input  wire logic   clk,
	output logic [30:0] count_in,
	output logic [30:0] dir_in,
	output logic [30:0] reset_in
);
	initial begin
		count_in = '0;
		dir_in = '0;
		reset_in = '0;
	end
	// Two scans per level: one scan could fall between samples
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			count_in[idx] <= 1'b1;
			repeat (2 * SCAN) @(posedge clk);
			count_in[idx] <= 1'b0;
			repeat (2 * SCAN) @(posedge clk);
		end
	endtask
	task automatic set_ctl(input int idx, input logic cnt, input logic down, input logic clr);
		@(posedge clk);
		count_in[idx] <= cnt;
		dir_in[idx] <= down;
		reset_in[idx] <= clr;
		repeat (2 * SCAN) @(posedge clk);
	endtask
endmodule

// file: multimode_event_counter.sv
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - Mode 0 coil simply follows the count input level; no preset, no reset.
// - Mode 1 counts up from zero, freezes at preset, coil on from then.
// - Mode 1 value is lost on power restart or run/stop; restarts at zero counting up.
// - Volatile init and reset give zero counting up, preset counting down except in modes 5 and 6 (zero).
// - Counting happens only on rising edges of the count input, in mode 7 on those of the selected fast input.
// - Mode 2 coil on at preset, counting continues up to 65535.
// - Mode 1 counting down restarts from preset after power loss.
// - Mode 3 is mode 1 but keeps its value through power loss.
// - Modes 3, 4, 6 keep value over run/stop only with keep option set.
// - Mode 4 is mode 2 but keeps its value through power loss.
// - Mode 5 coil on while value at or above preset, either direction.
// - Mode 5 value becomes zero on reset, power loss or run/stop.
// - Mode 6 is mode 5 but keeps its value through power loss.
// - Two fast inputs give two independent high-speed counting channels.
// - Mode 7 counts selected fast input edges, stops and sets coil at preset.
// - Mode 7 reset clears value and coil; release resumes counting.
// - Mode 7 value and preset span zero to 999999.
// - Thirty-one counters, each configured through its own index.
// - Counting down decrements by one per edge and halts at zero.
module multimode_event_counter
	import event_counter_pkg::*;
#(
	parameter int SCAN_CLKS = SCAN_CYCLES
) (
	input  wire logic                                   clk,
	input  wire logic                                   rst,
	// Ladder-side per-instance controls, same clock domain
	input  wire logic [event_counter_pkg::NUM_COUNTERS-1:0] count_in,
	input  wire logic [event_counter_pkg::NUM_COUNTERS-1:0] dir_in,
	input  wire logic [event_counter_pkg::NUM_COUNTERS-1:0] reset_in,
	// System events, one-cycle pulses
	input  wire logic                                   power_restore,
	input  wire logic                                   run_stop_switch,
	// Fast count pins
	input  wire logic                                   fast_input_a,
	input  wire logic                                   fast_input_b,
	output logic [event_counter_pkg::NUM_COUNTERS-1:0]      coil,
	// Classic Wishbone slave
	input  wire logic                                   wb_cyc_i,
	input  wire logic                                   wb_stb_i,
	input  wire logic                                   wb_we_i,
	input  wire logic [8:0]                             wb_adr_i,
	input  wire logic [31:0]                            wb_dat_i,
	input  wire logic [3:0]                             wb_sel_i,
	output logic [31:0]                                 wb_dat_o,
	output logic                                        wb_ack_o
);
	import event_counter_pkg::*;

	logic                    scan_tick;
	logic                    fast_a_level;
	logic                    fast_b_level;
	logic                    fast_a_rise;
	logic                    fast_b_rise;

	logic [MODE_W-1:0]       cfg_mode   [NUM_COUNTERS];
	logic                    cfg_keep   [NUM_COUNTERS];
	logic                    cfg_fast   [NUM_COUNTERS];
	logic [VALUE_W-1:0]      preset     [NUM_COUNTERS];
	logic [VALUE_W-1:0]      value      [NUM_COUNTERS];
	logic [NUM_COUNTERS-1:0] count_prev;

	logic                    bus_req;
	logic                    bus_write;
	logic [1:0]              region;
	logic [INDEX_W-1:0]      index;
	logic                    index_ok;
	logic [31:0]             next_dat;

	scan_divider #(
		.CYCLES (SCAN_CLKS)
	) u_scan (
		.clk  (clk),
		.rst  (rst),
		.tick (scan_tick)
	);

	pin_edge_sync u_fast_a (
		.clk   (clk),
		.rst   (rst),
		.pin   (fast_input_a),
		.level (fast_a_level),
		.rise  (fast_a_rise)
	);

	pin_edge_sync u_fast_b (
		.clk   (clk),
		.rst   (rst),
		.pin   (fast_input_b),
		.level (fast_b_level),
		.rise  (fast_b_rise)
	);

	// Bus decode
	assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_write = bus_req & wb_we_i & wb_sel_i[0];
	assign region    = wb_adr_i[REGION_LSB+1:REGION_LSB];
	assign index     = wb_adr_i[REGION_LSB-1:INDEX_LSB];
	assign index_ok  = (32'(index) < NUM_COUNTERS);

	// One wait-free cycle: ack the cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_comb begin
		next_dat = 32'h0000_0000;
		if (index_ok) begin
			unique case (region)
				REGION_CONFIG: begin
					next_dat[CFG_MODE_LSB +: MODE_W] = cfg_mode[index];
					next_dat[CFG_KEEP_BIT]           = cfg_keep[index];
					next_dat[CFG_FAST_BIT]           = cfg_fast[index];
				end
				REGION_PRESET: begin
					next_dat[VALUE_W-1:0] = preset[index];
				end
				REGION_VALUE: begin
					next_dat[VALUE_W-1:0] = value[index];
				end
				REGION_STATUS: begin
					if (index == STATUS_COILS) begin
						next_dat[NUM_COUNTERS-1:0] = coil;
					end else if (index == STATUS_FAST) begin
						next_dat[1:0] = {fast_b_level, fast_a_level};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req) begin
			wb_dat_o <= next_dat;
		end
	end

	// Previous scan sample of each general count input
	always_ff @(posedge clk) begin
		if (rst) begin
			count_prev <= '0;
		end else if (scan_tick) begin
			count_prev <= count_in;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_ctr
			mode_t              mode;
			logic               down;
			logic               volatile_mode;
			logic               cmp_mode;
			logic               coil_mode;
			logic               fast_mode;
			logic               reinit;
			logic               pulse;
			logic               hit_cfg;
			logic               hit_preset;
			logic               hit_value;
			logic [VALUE_W-1:0] init_value;
			logic [VALUE_W-1:0] up_limit;
			logic [VALUE_W-1:0] next_value;
			logic               next_coil;

			assign hit_cfg    = bus_write && region == REGION_CONFIG && index == INDEX_W'(gi);
			assign hit_preset = bus_write && region == REGION_PRESET && index == INDEX_W'(gi);
			assign hit_value  = bus_write && region == REGION_VALUE && index == INDEX_W'(gi);

			assign mode      = mode_t'(cfg_mode[gi]);

			// Mode table: limit and keep rule side by side
			always_comb begin
				coil_mode     = 1'b0;
				cmp_mode      = 1'b0;
				fast_mode     = 1'b0;
				volatile_mode = 1'b0;
				up_limit      = VALUE_MAX;
				unique case (mode)
					MODE_COIL: begin
						coil_mode = 1'b1;
					end
					MODE_STOP_VOLATILE: begin
						volatile_mode = 1'b1;
						up_limit      = preset[gi];
					end
					MODE_OVER_VOLATILE: begin
						volatile_mode = 1'b1;
						up_limit      = OVERFLOW_MAX;
					end
					MODE_STOP_KEEP: begin
						up_limit = preset[gi];
					end
					MODE_OVER_KEEP: begin
						up_limit = OVERFLOW_MAX;
					end
					MODE_CMP_VOLATILE: begin
						cmp_mode      = 1'b1;
						volatile_mode = 1'b1;
					end
					MODE_CMP_KEEP: begin
						cmp_mode = 1'b1;
					end
					MODE_FAST: begin
						fast_mode     = 1'b1;
						volatile_mode = 1'b1;
						up_limit      = preset[gi];
					end
					// Codes above seven: full range, kept over power loss
					default: begin
						up_limit = VALUE_MAX;
					end
				endcase
			end

			// Fast mode counts up only
			always_comb begin
				down = dir_in[gi];
				if (fast_mode) begin
					down = 1'b0;
				end
			end

			// Zero up, preset down; compare and fast modes always zero
			always_comb begin
				init_value = VALUE_ZERO;
				if (down && !cmp_mode) begin
					init_value = preset[gi];
				end
			end

			// Power loss drops only volatile values; run/stop also drops unkept ones
			always_comb begin
				reinit = 1'b0;
				if (power_restore && volatile_mode) begin
					reinit = 1'b1;
				end
				if (run_stop_switch && (volatile_mode || !cfg_keep[gi])) begin
					reinit = 1'b1;
				end
			end

			// Fast mode takes the selected pin edge on any clock
			always_comb begin
				pulse = scan_tick && count_in[gi] && !count_prev[gi];
				if (fast_mode && cfg_fast[gi]) begin
					pulse = fast_b_rise;
				end else if (fast_mode) begin
					pulse = fast_a_rise;
				end
			end

			always_comb begin
				next_value = value[gi];
				if (coil_mode) begin
					next_value = VALUE_ZERO;
				end else if (reset_in[gi] || reinit) begin
					next_value = init_value;
				end else if (pulse) begin
					if (down) begin
						if (value[gi] != VALUE_ZERO) begin
							next_value = value[gi] - 20'h0_0001;
						end
					end else if (value[gi] < up_limit) begin
						next_value = value[gi] + 20'h0_0001;
					end
				end
			end

			always_comb begin
				next_coil = 1'b0;
				if (coil_mode) begin
					next_coil = count_in[gi];
				end else if (reset_in[gi]) begin
					next_coil = 1'b0;
				end else if (cmp_mode) begin
					next_coil = value[gi] >= preset[gi];
				end else if (down) begin
					next_coil = value[gi] == VALUE_ZERO;
				end else begin
					next_coil = value[gi] >= preset[gi];
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					cfg_mode[gi] <= CFG_MODE_RESET;
					cfg_keep[gi] <= 1'b0;
					cfg_fast[gi] <= 1'b0;
				end else if (hit_cfg) begin
					cfg_mode[gi] <= wb_dat_i[CFG_MODE_LSB +: MODE_W];
					cfg_keep[gi] <= wb_dat_i[CFG_KEEP_BIT];
					cfg_fast[gi] <= wb_dat_i[CFG_FAST_BIT];
				end
			end

			// Preset clamped so the range stays within six digits
			always_ff @(posedge clk) begin
				if (rst) begin
					preset[gi] <= PRESET_RESET;
				end else if (hit_preset) begin
					if (wb_dat_i[VALUE_W-1:0] > VALUE_MAX) begin
						preset[gi] <= VALUE_MAX;
					end else begin
						preset[gi] <= wb_dat_i[VALUE_W-1:0];
					end
				end
			end

			// Software load wins over a count in the same cycle
			always_ff @(posedge clk) begin
				if (rst) begin
					value[gi] <= VALUE_ZERO;
				end else if (hit_value) begin
					if (wb_dat_i[VALUE_W-1:0] > VALUE_MAX) begin
						value[gi] <= VALUE_MAX;
					end else begin
						value[gi] <= wb_dat_i[VALUE_W-1:0];
					end
				end else begin
					value[gi] <= next_value;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					coil[gi] <= 1'b0;
				end else begin
					coil[gi] <= next_coil;
				end
			end
		end
	endgenerate
endmodule

// file: multimode_event_counter_sva.sv
`timescale 1ns/1ps
module multimode_event_counter_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [30:0] count_in,
	input wire logic [30:0] reset_in,
	input wire logic [30:0] coil,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [8:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	logic [3:0] mode0;
	logic       req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Mirror taken at the request edge, so it never lags the design
	always_ff @(posedge clk) begin
		if (rst)
			mode0 <= 4'h0;
		else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 9'h000)
			mode0 <= wb_dat_i[3:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ACK_NEXT: assert property (req |=> wb_ack_o)
		else $error("no ack after request");
	AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_UNMAPPED: assert property (req && !wb_we_i && wb_adr_i == 9'h07C |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_DAT_WIDTH: assert property (wb_ack_o && wb_adr_i[8:7] != 2'h3 |-> wb_dat_o[31:20] == 12'h000)
		else $error("read data above value range");
	AST_DAT_HOLD: assert property (!wb_ack_o && !$past(rst) |-> $stable(wb_dat_o))
		else $error("read data moved without ack");
	AST_COIL_FOLLOW: assert property (!$past(rst) && mode0 == 4'h0 && $past(mode0) == 4'h0 |-> coil[0] == $past(count_in[0]))
		else $error("mode 0 coil not following input");
	AST_RESET_COIL: assert property ((reset_in[0] && mode0 != 4'h0) [*3] |-> !coil[0])
		else $error("coil on while held in reset");
endmodule
bind multimode_event_counter multimode_event_counter_sva u_sva (
	.clk(clk), .rst(rst), .count_in(count_in), .reset_in(reset_in), .coil(coil),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// file: multimode_event_counter_tb.sv
`timescale 1ns/1ps
module multimode_event_counter_tb;
	import event_counter_pkg::*;
	localparam int SCAN = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [30:0] count_in;
	logic [30:0] dir_in;
	logic [30:0] reset_in;
	logic [30:0] coil;
	logic        pwr = 1'b0;
	logic        rsw = 1'b0;
	logic        fa = 1'b0;
	logic        fb = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [8:0]  adr = 9'h000;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] dat_o;
	logic        ack;
	logic [31:0] rdat;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD %s expected %h seen %h", what, exp, got); end end
	multimode_event_counter #(.SCAN_CLKS(SCAN)) u_multimode_event_counter (
		.clk(clk), .rst(rst), .count_in(count_in), .dir_in(dir_in), .reset_in(reset_in),
		.power_restore(pwr), .run_stop_switch(rsw), .fast_input_a(fa), .fast_input_b(fb),
		.coil(coil), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack)
	);
	ladder_model #(.SCAN(SCAN)) u_ladder_model (
		.clk(clk), .count_in(count_in), .dir_in(dir_in), .reset_in(reset_in)
	);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(what, exp, rdat)
	endtask
	task automatic ev(input logic p);
		@(posedge clk);
		pwr <= p;
		rsw <= !p;
		@(posedge clk);
		pwr <= 1'b0;
		rsw <= 1'b0;
	endtask
	task automatic fpulse(input logic b, input int n);
		repeat (n) begin
			@(posedge clk);
			fa <= !b;
			fb <= b;
			repeat (4) @(posedge clk);
			fa <= 1'b0;
			fb <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic t_mode01;
		rd(9'h07C, 32'h0000_0000, "unmapped");
		bus(1'b1, 9'h080, 32'h000F_FFFF);
		rd(9'h080, {12'h000, VALUE_MAX}, "preset clamp");
		u_ladder_model.set_ctl(0, 1'b1, 1'b0, 1'b1);
		`CHK("mode 0 coil", 1'b1, coil[0])
		rd(9'h180, 32'h0000_0001, "coil status");
		u_ladder_model.set_ctl(0, 1'b0, 1'b0, 1'b0);
		bus(1'b1, 9'h080, 32'h0000_0002);
		bus(1'b1, 9'h000, 32'h0000_0001);
		u_ladder_model.pulse(0, 3);
		rd(9'h100, 32'h0000_0002, "mode 1 freeze");
		`CHK("mode 1 coil", 1'b1, coil[0])
		ev(1'b1);
		rd(9'h100, 32'h0000_0000, "mode 1 power");
		u_ladder_model.set_ctl(0, 1'b0, 1'b1, 1'b0);
		ev(1'b1);
		rd(9'h100, 32'h0000_0002, "down power");
		u_ladder_model.pulse(0, 1);
		rd(9'h100, 32'h0000_0001, "down step");
		u_ladder_model.pulse(0, 2);
		rd(9'h100, 32'h0000_0000, "down floor");
		u_ladder_model.set_ctl(0, 1'b0, 1'b1, 1'b1);
		rd(9'h100, 32'h0000_0002, "down reset");
		u_ladder_model.set_ctl(0, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_keep;
		bus(1'b1, 9'h000, 32'h0000_0002);
		bus(1'b1, 9'h100, 32'h0000_0001);
		u_ladder_model.pulse(0, 2);
		`CHK("mode 2 coil", 1'b1, coil[0])
		bus(1'b1, 9'h100, 32'h0000_FFFE);
		u_ladder_model.pulse(0, 3);
		rd(9'h100, {12'h000, OVERFLOW_MAX}, "mode 2 limit");
		bus(1'b1, 9'h000, 32'h0000_0004);
		bus(1'b1, 9'h100, 32'h0000_0005);
		ev(1'b1);
		rd(9'h100, 32'h0000_0005, "mode 4 power");
		bus(1'b1, 9'h000, 32'h0000_0003);
		ev(1'b1);
		rd(9'h100, 32'h0000_0005, "mode 3 power");
		ev(1'b0);
		rd(9'h100, 32'h0000_0000, "run stop drop");
		bus(1'b1, 9'h000, 32'h0000_0013);
		bus(1'b1, 9'h100, 32'h0000_0001);
		ev(1'b0);
		rd(9'h100, 32'h0000_0001, "run stop keep");
	endtask
	task automatic t_cmp_fast;
		bus(1'b1, 9'h080, 32'h0000_0003);
		bus(1'b1, 9'h000, 32'h0000_0005);
		bus(1'b1, 9'h100, 32'h0000_0002);
		u_ladder_model.pulse(0, 1);
		`CHK("compare up coil", 1'b1, coil[0])
		u_ladder_model.set_ctl(0, 1'b0, 1'b1, 1'b0);
		u_ladder_model.pulse(0, 1);
		`CHK("compare down coil", 1'b0, coil[0])
		u_ladder_model.set_ctl(0, 1'b0, 1'b1, 1'b1);
		rd(9'h100, 32'h0000_0000, "compare reset");
		u_ladder_model.set_ctl(0, 1'b0, 1'b0, 1'b0);
		bus(1'b1, 9'h000, 32'h0000_0006);
		bus(1'b1, 9'h100, 32'h0000_0004);
		ev(1'b1);
		rd(9'h100, 32'h0000_0004, "mode 6 power");
		bus(1'b1, 9'h000, 32'h0000_0007);
		bus(1'b1, 9'h100, 32'h0000_0000);
		fpulse(1'b0, 5);
		rd(9'h100, 32'h0000_0003, "fast stop");
		`CHK("fast coil", 1'b1, coil[0])
		u_ladder_model.set_ctl(0, 1'b0, 1'b0, 1'b1);
		rd(9'h100, 32'h0000_0000, "fast reset");
		u_ladder_model.set_ctl(0, 1'b0, 1'b0, 1'b0);
		bus(1'b1, 9'h0F8, 32'h0000_0007);
		bus(1'b1, 9'h078, 32'h0000_0027);
		fpulse(1'b1, 2);
		rd(9'h178, 32'h0000_0002, "channel b");
		rd(9'h100, 32'h0000_0000, "channel a idle");
		fb <= 1'b1;
		repeat (3) @(posedge clk);
		rd(9'h184, 32'h0000_0002, "fast levels");
		fb <= 1'b0;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_mode01();
		t_keep();
		t_cmp_fast();
		finish_test();
	end
endmodule

// file: pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic meta;
	logic prev;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta  <= 1'b0;
			level <= 1'b0;
			prev  <= 1'b0;
			rise  <= 1'b0;
		end else begin
			meta  <= pin;
			level <= meta;
			prev  <= level;
			rise  <= level & ~prev;
		end
	end
endmodule

// file: scan_divider.sv
`timescale 1ns/1ps
module scan_divider #(
	parameter int CYCLES = 1250
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	logic [31:0] count;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (count == 32'(CYCLES - 1)) begin
			count <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule
